// >>> rtl/idcm_pkg.sv
// Package: constants for the input deglitch and clock monitor block
package idcm_pkg;

   // Clock rate
   localparam int CLK_MHZ = 250;

   // Nominal filter and detection times
   localparam int INPUT_FILTER_TIME_US = 200;
   localparam int RESET_FILTER_TIME_US = 10;
   localparam int CLOCK_FILTER_TIME_NS = 2000;
   localparam int CLK_LOW_FREQ_HZ      = 100;

   // Derived cycle counts
   localparam int INPUT_FILTER_CYC = INPUT_FILTER_TIME_US * CLK_MHZ;
   localparam int RESET_FILTER_CYC = RESET_FILTER_TIME_US * CLK_MHZ;
   localparam int CLOCK_FILTER_CYC = (CLOCK_FILTER_TIME_NS * CLK_MHZ) / 1000;
   localparam int CLK_LOW_CYC      = (CLK_MHZ * 1000000) / CLK_LOW_FREQ_HZ;

   // Counter width and channel count
   localparam int CNT_W  = 32;
   localparam int NCHAN  = 4;

   // Operating modes
   typedef enum logic [1:0] {
      IDCM_MODE_SLEEP,
      IDCM_MODE_NORMAL,
      IDCM_MODE_FAIL
   } idcm_mode_type;

endpackage

// >>> rtl/idcm_top.sv
// Input deglitchers, clock monitor and external switch control
`timescale 1ns/1ps
module idcm_top #(
   parameter int INPUT_FILTER_CYC = idcm_pkg::INPUT_FILTER_CYC,
   parameter int RESET_FILTER_CYC = idcm_pkg::RESET_FILTER_CYC,
   parameter int CLK_LOW_CYC      = idcm_pkg::CLK_LOW_CYC
) (
   input  wire logic                       clk_in,
   input  wire logic                       nrst_in,
   input  wire logic [idcm_pkg::NCHAN-1:0] direct_channel_inputs_in,
   input  wire logic                       fail_request_in,
   input  wire logic                       active_low_reset_input_in,
   input  wire logic                       ext_clock_in,
   input  wire logic                       spi_fail_in,
   input  wire logic                       sleep_request_in,
   input  wire logic                       status_read_in,
   input  wire logic [idcm_pkg::NCHAN-1:0] channel_on_command_in,
   input  wire logic [idcm_pkg::NCHAN-1:0] pwm_channel_in,
   input  wire logic                       ch6_on_in,
   input  wire logic                       ch6_pwm_in,
   output logic      [idcm_pkg::NCHAN-1:0] filtered_direct_input_out,
   output logic                            filtered_fail_request_out,
   output logic                            filtered_reset_n_out,
   output logic                            clock_fail_out,
   output logic      [idcm_pkg::NCHAN-1:0] channel_drive_out,
   output logic                            external_switch_control_output_out,
   output logic      [1:0]                 mode_out
);

   localparam int NI = idcm_pkg::NCHAN + 3;
   localparam logic [idcm_pkg::CNT_W-1:0] IN_LIM =
      idcm_pkg::CNT_W'(INPUT_FILTER_CYC - 1);
   localparam logic [idcm_pkg::CNT_W-1:0] RST_LIM =
      idcm_pkg::CNT_W'(RESET_FILTER_CYC - 1);
   localparam logic [idcm_pkg::CNT_W-1:0] CLK_FLT_LIM =
      idcm_pkg::CNT_W'(idcm_pkg::CLOCK_FILTER_CYC - 1);
   localparam logic [idcm_pkg::CNT_W-1:0] LOW_LIM =
      idcm_pkg::CNT_W'(CLK_LOW_CYC - 1);
   localparam logic [idcm_pkg::CNT_W-1:0] CNT_ZERO = '0;

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   logic [NI-1:0] raw_pins;
   logic [NI-1:0] sync1_r;
   logic [NI-1:0] sync2_r;

   assign raw_pins = {ext_clock_in, active_low_reset_input_in,
                      fail_request_in, direct_channel_inputs_in};

   // Two flops per pin; reset pin reads as asserted until seen high
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         sync1_r <= 7'h00;
         sync2_r <= 7'h00;
      end else begin
         sync1_r <= raw_pins;
         sync2_r <= sync1_r;
      end
   end

   // ----------------------------------------------------------------
   // Deglitchers, one counter per input
   // ----------------------------------------------------------------
   // One flop per generate block drives each bit, so one driver per bit
   wire logic [NI-1:0] filt_r;

   genvar gi;
   generate
      for (gi = 0; gi < NI; gi++) begin : g_dgl
         logic [idcm_pkg::CNT_W-1:0] cnt_r;
         logic [idcm_pkg::CNT_W-1:0] lim;
         logic                       differ;
         logic                       filtered_edge;
         logic                       flt_r;
         // Reset pin only filters falling edges
         assign lim = (gi == NI - 1) ? CLK_FLT_LIM :
                      (gi == NI - 2) ? RST_LIM : IN_LIM;
         assign filtered_edge = (gi != NI - 2) || flt_r;
         assign differ = sync2_r[gi] != flt_r;
         assign filt_r[gi] = flt_r;
         // Counter restarts on any bounce back: short pulses never pass, save high pulses on the reset pin
         always_ff @(posedge clk_in or negedge nrst_in) begin
            if (!nrst_in) begin
               cnt_r <= CNT_ZERO;
               flt_r <= 1'b0;
            end else if (!differ) begin
               cnt_r <= CNT_ZERO;
            end else if (!filtered_edge || cnt_r >= lim) begin
               cnt_r <= CNT_ZERO;
               flt_r <= sync2_r[gi];
            end else begin
               cnt_r <= cnt_r + 1'b1;
            end
         end
      end
   endgenerate

   assign filtered_direct_input_out =
      filt_r[idcm_pkg::NCHAN-1:0];
   assign filtered_fail_request_out = filt_r[idcm_pkg::NCHAN];
   assign filtered_reset_n_out      = filt_r[NI-2];

   // ----------------------------------------------------------------
   // Clock monitor
   // ----------------------------------------------------------------
   logic                       clk_prev_r;
   logic [idcm_pkg::CNT_W-1:0] low_cnt_r;
   logic                       clk_fault_r;
   logic                       clk_fail_latch_r;
   logic                       clk_edge;
   logic                       in_reset;

   assign clk_edge = filt_r[NI-1] && !clk_prev_r;
   assign in_reset = !filt_r[NI-2];

   // Period timer held in reset, so it runs from reset release
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         clk_prev_r  <= 1'b0;
         low_cnt_r   <= CNT_ZERO;
         clk_fault_r <= 1'b0;
      end else begin
         clk_prev_r <= filt_r[NI-1];
         if (in_reset || clk_edge) begin
            low_cnt_r   <= CNT_ZERO;
            clk_fault_r <= 1'b0;
         end else if (low_cnt_r >= LOW_LIM) begin
            clk_fault_r <= 1'b1;
         end else begin
            low_cnt_r <= low_cnt_r + 1'b1;
         end
      end
   end

   // Latch clears only with fault gone and a status read; set wins
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         clk_fail_latch_r <= 1'b0;
      end else if (clk_fault_r) begin
         clk_fail_latch_r <= 1'b1;
      end else if (status_read_in) begin
         clk_fail_latch_r <= 1'b0;
      end
   end

   assign clock_fail_out = clk_fail_latch_r;

   // ----------------------------------------------------------------
   // Mode and output selection
   // ----------------------------------------------------------------
   idcm_pkg::idcm_mode_type mode_r;
   idcm_pkg::idcm_mode_type mode_nxt;
   logic [idcm_pkg::NCHAN-1:0] drive_nxt;
   logic [idcm_pkg::NCHAN-1:0] drive_r;
   logic                       ext_nxt;
   logic                       ext_r;

   assign mode_nxt = (filtered_fail_request_out || spi_fail_in) ?
                        idcm_pkg::IDCM_MODE_FAIL :
                     sleep_request_in ? idcm_pkg::IDCM_MODE_SLEEP :
                        idcm_pkg::IDCM_MODE_NORMAL;

   // Fail: direct inputs; Sleep: all off; clock fault: on commands; else PWM
   assign drive_nxt =
      (mode_r == idcm_pkg::IDCM_MODE_FAIL) ? filtered_direct_input_out :
      (mode_r == idcm_pkg::IDCM_MODE_SLEEP) ? '0 :
      clk_fault_r ? channel_on_command_in :
      (channel_on_command_in & pwm_channel_in);

   // Host owns protection of the external switch, none here
   assign ext_nxt = (mode_r == idcm_pkg::IDCM_MODE_NORMAL) &&
                    ch6_on_in &&
                    (clk_fault_r || ch6_pwm_in);

   // Outputs registered so the pins never glitch on mode changes
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         mode_r  <= idcm_pkg::IDCM_MODE_SLEEP;
         drive_r <= 4'h0;
         ext_r   <= 1'b0;
      end else begin
         mode_r  <= in_reset ? idcm_pkg::IDCM_MODE_SLEEP : mode_nxt;
         drive_r <= drive_nxt;
         ext_r   <= ext_nxt;
      end
   end

   assign channel_drive_out                  = drive_r;
   assign external_switch_control_output_out = ext_r;
   assign mode_out                           = mode_r;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   // External switch output against mode and channel 6 settings
   chk_ext_off_mode: assert property (
      @(posedge clk_in) disable iff (!nrst_in)
      $past(mode_r) != idcm_pkg::IDCM_MODE_NORMAL |-> !ext_r)
      else $error("external switch driven outside Normal mode");
   chk_ext_off_sleep: assert property (
      @(posedge clk_in) disable iff (!nrst_in)
      ($past(mode_r) == idcm_pkg::IDCM_MODE_SLEEP ||
       $past(mode_r) == idcm_pkg::IDCM_MODE_FAIL) |-> !ext_r)
      else $error("external switch on in Sleep or Fail mode");
   chk_ext_follows_ch6: assert property (
      @(posedge clk_in) disable iff (!nrst_in)
      $past(mode_r) == idcm_pkg::IDCM_MODE_NORMAL && $past(ch6_on_in)
      && $past(ch6_pwm_in) |-> ext_r)
      else $error("external switch ignores channel 6 settings");
   // Channel drive source per mode and clock state
   chk_fail_direct: assert property (
      @(posedge clk_in) disable iff (!nrst_in)
      $past(mode_r) == idcm_pkg::IDCM_MODE_FAIL
      |-> drive_r == $past(filtered_direct_input_out))
      else $error("fail mode outputs not from direct inputs");
   chk_lowclk_cmd: assert property (
      @(posedge clk_in) disable iff (!nrst_in)
      $past(mode_r) == idcm_pkg::IDCM_MODE_NORMAL && $past(clk_fault_r)
      |-> drive_r == $past(channel_on_command_in))
      else $error("clock fail outputs not from on commands");
   chk_pwm_valid: assert property (
      @(posedge clk_in) disable iff (!nrst_in)
      $past(mode_r) == idcm_pkg::IDCM_MODE_NORMAL && !$past(clk_fault_r)
      |-> drive_r == $past(channel_on_command_in & pwm_channel_in))
      else $error("valid clock outputs not from PWM");
   // Clock fail latch set and hold
   chk_latch_hold: assert property (
      @(posedge clk_in) disable iff (!nrst_in)
      clk_fail_latch_r && !status_read_in |=> clk_fail_latch_r)
      else $error("clock fail latch cleared without read");
   chk_latch_set: assert property (
      @(posedge clk_in) disable iff (!nrst_in)
      clk_fault_r |=> clk_fail_latch_r)
      else $error("clock fault not latched");
   // Filter edges against the synchronised pins
   chk_fail_pulse: assert property (
      @(posedge clk_in) disable iff (!nrst_in)
      $rose(filtered_fail_request_out) |-> $past(sync2_r[idcm_pkg::NCHAN]))
      else $error("fail request rose without input high");
   chk_rst_rise: assert property (
      @(posedge clk_in) disable iff (!nrst_in)
      sync2_r[NI-2] && !filt_r[NI-2] |=> filt_r[NI-2])
      else $error("reset release delayed by filter");

endmodule // idcm_top

// >>> tb/idcm_mcu_model.sv
// Host-side model: external clock source and status read strobe
`timescale 1ns/1ps
module idcm_mcu_model (
   input  wire logic        clk_in,
   input  wire logic        run_in,
   input  wire logic [15:0] half_in,
   input  wire logic        read_req_in,
   output logic             ext_clock_out,
   output logic             status_read_out
);
   logic [15:0] cnt_r;
   initial begin
      cnt_r = 16'h0000;
      ext_clock_out = 1'b0;
      status_read_out = 1'b0;
   end
   // Host owns protection and current feedback of the switch
   // Clock rests low when stopped, so no stray edge leaks out
   always @(posedge clk_in) begin
      status_read_out <= #1 read_req_in;
      if (!run_in || cnt_r + 16'h0001 >= half_in) begin
         cnt_r <= #1 16'h0000;
         ext_clock_out <= #1 run_in & ~ext_clock_out;
      end else begin
         cnt_r <= #1 cnt_r + 16'h0001;
      end
   end
endmodule // idcm_mcu_model

// >>> tb/idcm_top_tb.sv
// Self-checking bench for the deglitch and clock monitor block
`timescale 1ns/1ps
module idcm_top_tb;
   localparam int LIM = 20; // Short filter keeps the run brief
   logic [3:0]  din = 4'h0, on = 4'h0, pwm = 4'h0, fdi, drv, v, prev;
   logic        clk_in = 1'b0, nrst_in = 1'b0, rst_pin = 1'b1;
   logic        fail_req = 1'b0, spi_fail = 1'b0, sleep_req = 1'b0;
   logic        read_req = 1'b0, on6 = 1'b0, pwm6 = 1'b0, run = 1'b1;
   logic        ext_clk, rd, ffail, frst, cfail, ext;
   logic [15:0] half = 16'h0258;
   logic [1:0]  mode;
   logic [31:0] seed = 32'h0001_8496;
   int          n_errors = 0, num_checks = 0, i;
   always #2 clk_in = ~clk_in;
   idcm_top #(.INPUT_FILTER_CYC(LIM), .RESET_FILTER_CYC(10),
      .CLK_LOW_CYC(2000)) u_idcm_top (.clk_in(clk_in), .nrst_in(nrst_in),
      .direct_channel_inputs_in(din), .fail_request_in(fail_req),
      .active_low_reset_input_in(rst_pin), .ext_clock_in(ext_clk),
      .spi_fail_in(spi_fail), .sleep_request_in(sleep_req),
      .status_read_in(rd), .channel_on_command_in(on),
      .pwm_channel_in(pwm), .ch6_on_in(on6), .ch6_pwm_in(pwm6),
      .filtered_direct_input_out(fdi), .filtered_fail_request_out(ffail),
      .filtered_reset_n_out(frst), .clock_fail_out(cfail),
      .channel_drive_out(drv), .external_switch_control_output_out(ext),
      .mode_out(mode));
   idcm_mcu_model u_idcm_mcu_model (.clk_in(clk_in), .run_in(run),
      .half_in(half), .read_req_in(read_req), .ext_clock_out(ext_clk),
      .status_read_out(rd));
   task automatic step(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // A wait that used up its bound ends the run
   task automatic bound(input int k, input int n);
      num_checks++;
      if (k >= n) begin
         n_errors++;
         $display("MISMATCH t=%0t wait=%h limit=%h", $time, k, n);
         print_verdict();
      end
   endtask
   task automatic print_verdict();
      $display("checks=%0d errors=%0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   function automatic logic [3:0] rnd4();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[3:0];
   endfunction
   // Expected {ext, drive} from mode and clock fault
   function automatic logic [7:0] exp_out(input logic [1:0] m, input logic f);
      if (m == 2'h1) return {3'h0, on6 & (f | pwm6), f ? on : on & pwm};
      else if (m == 2'h2) return {4'h0, din};
      else return 8'h00;
   endfunction
   task automatic cmd_chk(input logic f);
      on = rnd4();
      pwm = rnd4();
      {on6, pwm6} = 2'(rnd4());
      step(2);
      chk({ext, drv}, exp_out(2'h1, f));
   endtask
   // One-cycle status read strobe, passed on by the host model
   task automatic status_read();
      read_req = 1'b1;
      step(1);
      read_req = 1'b0;
   endtask
   initial begin
      step(2);
      chk({mode, cfail, frst, ffail, fdi}, 8'h00);
      step(1);
      nrst_in = 1'b1;
      for (i = 0; i < 8 && frst !== 1'b1; i++) step(1);
      bound(i, 8);
      step(2);
      chk(mode, 8'h01);
      // Short low glitch on reset pin, then a real one
      rst_pin = 1'b0;
      step(5);
      rst_pin = 1'b1;
      step(20);
      chk(frst, 8'h01);
      rst_pin = 1'b0;
      step(8);
      chk(frst, 8'h01);
      for (i = 0; i < 12 && frst !== 1'b0; i++) step(1);
      bound(i, 12);
      rst_pin = 1'b1;
      step(8);
      chk({mode, frst}, 8'h03);
      for (int k = 0; k < 6; k++) begin
         prev = din;
         v = (k == 0) ? 4'hF : rnd4();
         din = v;
         step(LIM / 2);
         din = prev;
         step(LIM + 8);
         chk(fdi, prev);
         din = v;
         step(LIM - 2);
         chk(fdi, prev);
         step(10);
         chk(fdi, v);
      end
      chk(cfail, 8'h00);
      repeat (8) cmd_chk(1'b0);
      // Too fast a clock never passes the clock filter
      half = 16'h0064;
      for (i = 0; i < 4000 && cfail !== 1'b1; i++) step(1);
      bound(i, 4000);
      status_read();
      step(3);
      chk(cfail, 8'h01);
      repeat (4) cmd_chk(1'b1);
      // Recovery may need a full slow period plus the filter time
      half = 16'h0258;
      step(2500);
      chk(cfail, 8'h01);
      status_read();
      for (i = 0; i < 6 && cfail !== 1'b0; i++) step(1);
      bound(i, 6);
      cmd_chk(1'b0);
      // Stopped clock: below the low frequency limit
      run = 1'b0;
      for (i = 0; i < 4000 && cfail !== 1'b1; i++) step(1);
      bound(i, 4000);
      repeat (2) cmd_chk(1'b1);
      run = 1'b1;
      step(2500);
      status_read();
      for (i = 0; i < 6 && cfail !== 1'b0; i++) step(1);
      bound(i, 6);
      cmd_chk(1'b0);
      sleep_req = 1'b1;
      step(3);
      chk({mode, ext, drv}, 8'h00);
      sleep_req = 1'b0;
      {on6, pwm6} = 2'h3;
      fail_req = 1'b1;
      step(LIM - 2);
      chk(mode, 8'h01);
      for (i = 0; i < 12 && mode !== 2'h2; i++) step(1);
      bound(i, 12);
      step(2);
      chk({ffail, ext}, 8'h02);
      chk(drv, exp_out(2'h2, 1'b0));
      fail_req = 1'b0;
      for (i = 0; i < LIM + 12 && mode !== 2'h1; i++) step(1);
      bound(i, LIM + 12);
      spi_fail = 1'b1;
      step(3);
      chk({mode, ext}, 8'h04);
      print_verdict();
   end
endmodule // idcm_top_tb
